// ===== hdl/afc_adc_fifo_ctrl.sv
/*
  converter start control, 16-entry result FIFO, error flags and the
  byte-wide register file on an AXI4-Lite slave.
  assumes a 40 MHz clock, trigger and timer lines from pins, and a
  front end that supplies the 12-bit code on the same clock.
*/
`include "afc_defines.svh"
`default_nettype none
module afc_adc_fifo_ctrl #(
  parameter logic [7:0] CAL_OFFSET = 8'h00,
  parameter logic [7:0] CAL_GAIN = 8'h00
) (
  input wire logic clock,
  input wire logic reset,
  input wire afc_pkg::afc_axi_req_s axiReq,
  output var afc_pkg::afc_axi_rsp_s axiRsp,
  input wire logic sampleTimerOutput,
  input wire logic externalConvertTrigger_n,
  input wire logic [11:0] adcCode,
  output logic timerLevel,
  output logic resultAvailable,
  output logic irqLine
);
  afc_pkg::afc_state_s state_ff;
  afc_pkg::afc_state_s nxt_state;
  logic awReady;
  logic wReady;
  logic doWrite;
  logic clearWrite;
  logic arTake;
  logic [4:0] rdIdx;
  logic [8:0] readWord;
  logic tmrEff;
  logic acqEnable;
  logic trigEdge;
  logic tmrEdge;
  logic startPulse;
  logic popReq;
  logic pushOk;
  logic ovfEvent;
  logic convDone;
  logic [15:0] convData;
  logic convOverrun;
  logic convBusy;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic wrMapped(input logic [4:0] idx);
    case (idx)
      `AFC_IDX_CMD1, `AFC_IDX_CLEAR, `AFC_IDX_TIMER_CLR, `AFC_IDX_CMD2,
      `AFC_IDX_CNT0_DATA, `AFC_IDX_CNT_MODE: wrMapped = 1'h1;
      default: wrMapped = 1'h0;
    endcase
  endfunction

  // read mux: bit 8 marks a mapped index
  function automatic logic [8:0] readReg(input logic [4:0] idx,
                                         input afc_pkg::afc_state_s s);
    logic [15:0] head;
    head = s.fifo[s.rdPtr];
    readReg = {1'h1, 8'h00};
    case (idx)
      `AFC_IDX_STAT1: begin
        readReg[`AFC_STAT1_AVAIL_BIT] = (s.count != 5'h00);
        readReg[`AFC_STAT1_ERR_BIT] = s.overflow | s.overrun;
      end
      `AFC_IDX_STAT2: begin
        readReg[`AFC_STAT2_OVF_BIT] = s.overflow;
        readReg[`AFC_STAT2_OVR_BIT] = s.overrun;
      end
      `AFC_IDX_FIFO_LSB: readReg[7:0] = head[7:0];
      `AFC_IDX_FIFO_MSB: readReg[7:0] = head[15:8];
      // write-only registers give nothing back
      `AFC_IDX_CLEAR, `AFC_IDX_TIMER_CLR, `AFC_IDX_CNT0_DATA,
      `AFC_IDX_CNT_MODE: readReg[7:0] = 8'h00;
      `AFC_IDX_CIS_CODE: readReg[7:0] = `AFC_TUPLE_CODE;
      `AFC_IDX_CIS_LINK: readReg[7:0] = `AFC_TUPLE_LINK;
      `AFC_IDX_CIS_GAIN: readReg[7:0] = `AFC_GAIN_CODE_SE5V;
      `AFC_IDX_CIS_OFS: readReg[7:0] = CAL_OFFSET;
      `AFC_IDX_CIS_GERR: readReg[7:0] = CAL_GAIN;
      default: readReg = 9'h000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes and derived events
  assign awReady = !state_ff.awHave && !state_ff.bvalid;
  assign wReady = !state_ff.wHave && !state_ff.bvalid;
  assign doWrite = state_ff.awHave && state_ff.wHave && !state_ff.bvalid;
  assign clearWrite = doWrite && state_ff.wLane &&
                      (state_ff.awIdx == `AFC_IDX_CLEAR);
  assign arTake = axiReq.arvalid && !state_ff.rvalid;
  // only the low five word-address bits decode
  assign rdIdx = axiReq.araddr[6:2];
  assign readWord = readReg(rdIdx, state_ff);

  always_comb begin
    case (state_ff.tmrMode)
      afc_pkg::TMR_HIGH: tmrEff = 1'h1;
      afc_pkg::TMR_LOW: tmrEff = 1'h0;
      afc_pkg::TMR_PIN: tmrEff = state_ff.tmrStable;
      default: tmrEff = 1'h0;
    endcase
  end

  assign acqEnable = !state_ff.cmd2[`AFC_CMD2_DISABLE_BIT];
  assign trigEdge = state_ff.trigStable && !state_ff.prevTrig;
  assign tmrEdge = tmrEff && !state_ff.prevTmr;
  // trigger counts only while the timer line is high
  assign startPulse = acqEnable && (tmrEdge || (trigEdge && tmrEff));
  // the high byte pops only after the low byte
  assign popReq = arTake && (rdIdx == `AFC_IDX_FIFO_MSB) &&
                  state_ff.lowSeen && (state_ff.count != 5'h00);
  assign pushOk = convDone && ((state_ff.count != `AFC_FIFO_DEPTH) || popReq);
  assign ovfEvent = convDone && !clearWrite && !popReq &&
                    (state_ff.count == `AFC_FIFO_DEPTH);

  afc_conv_seq convSeq (
    .clock(clock),
    .reset(reset),
    .startPulse(startPulse),
    .adcCode(adcCode),
    .doneValid(convDone),
    .doneData(convData),
    .overrunPulse(convOverrun),
    .busy(convBusy)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    if (axiReq.awvalid && awReady) begin
      nxt_state.awHave = 1'h1;
      nxt_state.awIdx = axiReq.awaddr[6:2];
    end
    if (axiReq.wvalid && wReady) begin
      nxt_state.wHave = 1'h1;
      nxt_state.wByte = axiReq.wdata[7:0];
      nxt_state.wLane = axiReq.wstrb[0];
    end
    if (state_ff.bvalid && axiReq.bready) begin
      nxt_state.bvalid = 1'h0;
    end
    if (doWrite) begin
      nxt_state.awHave = 1'h0;
      nxt_state.wHave = 1'h0;
      nxt_state.bvalid = 1'h1;
      nxt_state.bresp = wrMapped(state_ff.awIdx) ? `AFC_RESP_OKAY :
                                                   `AFC_RESP_SLVERR;
      if (state_ff.wLane) begin
        // a write replaces every bit at once
        case (state_ff.awIdx)
          `AFC_IDX_CMD1: nxt_state.cmd1 = state_ff.wByte;
          `AFC_IDX_CMD2: nxt_state.cmd2 = state_ff.wByte;
          `AFC_IDX_CNT0_DATA: nxt_state.tmrMode = afc_pkg::TMR_PIN;
          `AFC_IDX_CNT_MODE: begin
            if (state_ff.wByte == `AFC_MODE_FORCE_HIGH) begin
              nxt_state.tmrMode = afc_pkg::TMR_HIGH;
            end else if (state_ff.wByte == `AFC_MODE_FORCE_LOW) begin
              nxt_state.tmrMode = afc_pkg::TMR_LOW;
            end
          end
          default: nxt_state.cmd1 = state_ff.cmd1;
        endcase
      end
    end
    if (state_ff.rvalid && axiReq.rready) begin
      nxt_state.rvalid = 1'h0;
    end
    if (arTake) begin
      nxt_state.rvalid = 1'h1;
      nxt_state.rByte = readWord[7:0];
      nxt_state.rresp = readWord[8] ? `AFC_RESP_OKAY : `AFC_RESP_SLVERR;
      if (rdIdx == `AFC_IDX_FIFO_LSB) begin
        nxt_state.lowSeen = 1'h1;
      end
    end
    // pin synchronisers, a level counts once stages two and three agree
    nxt_state.trigSync = {state_ff.trigSync[1:0], externalConvertTrigger_n};
    if (state_ff.trigSync[2] == state_ff.trigSync[1]) begin
      nxt_state.trigStable = state_ff.trigSync[2];
    end
    nxt_state.prevTrig = state_ff.trigStable;
    nxt_state.tmrSync = {state_ff.tmrSync[1:0], sampleTimerOutput};
    if (state_ff.tmrSync[2] == state_ff.tmrSync[1]) begin
      nxt_state.tmrStable = state_ff.tmrSync[2];
    end
    nxt_state.prevTmr = tmrEff;
    // result FIFO
    if (convDone) begin
      nxt_state.lastResult = convData;
    end
    if (clearWrite) begin
      // one stale word, the latest conversion
      nxt_state.fifo[state_ff.rdPtr] = convDone ? convData :
                                                  state_ff.lastResult;
      nxt_state.wrPtr = state_ff.rdPtr + 4'h1;
      nxt_state.count = 5'h01;
      nxt_state.lowSeen = 1'h0;
    end else begin
      if (popReq) begin
        nxt_state.rdPtr = state_ff.rdPtr + 4'h1;
        nxt_state.lowSeen = 1'h0;
      end
      if (pushOk) begin
        nxt_state.fifo[state_ff.wrPtr] = convData;
        nxt_state.wrPtr = state_ff.wrPtr + 4'h1;
      end
      case ({pushOk, popReq})
        2'h2: nxt_state.count = state_ff.count + 5'h01;
        2'h1: nxt_state.count = state_ff.count - 5'h01;
        default: nxt_state.count = state_ff.count;
      endcase
    end
    // error flags, an overrun in the clear cycle still sets; overflow is masked by the clear
    if (clearWrite) begin
      nxt_state.overflow = 1'h0;
      nxt_state.overrun = 1'h0;
    end
    if (ovfEvent) begin
      nxt_state.overflow = 1'h1;
    end
    if (convOverrun) begin
      nxt_state.overrun = 1'h1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      // power-up matches the state after initialisation
      state_ff <= '0;
      state_ff.cmd1 <= `AFC_CMD1_RESET;
      state_ff.cmd2 <= `AFC_CMD2_RESET;
      state_ff.tmrMode <= afc_pkg::TMR_HIGH;
      state_ff.trigSync <= 3'h7;
      state_ff.trigStable <= 1'h1;
      state_ff.prevTrig <= 1'h1;
      state_ff.prevTmr <= 1'h1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    axiRsp.awready = awReady;
    axiRsp.wready = wReady;
    axiRsp.bvalid = state_ff.bvalid;
    axiRsp.bresp = state_ff.bresp;
    axiRsp.arready = !state_ff.rvalid;
    axiRsp.rvalid = state_ff.rvalid;
    axiRsp.rdata = {24'h000000, state_ff.rByte};
    axiRsp.rresp = state_ff.rresp;
  end

  assign timerLevel = tmrEff;
  assign resultAvailable = (state_ff.count != 5'h00);
  // single level interrupt line
  assign irqLine = state_ff.cmd1[`AFC_CMD1_INTEN_BIT] && resultAvailable;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_avail_deadline: assert property (
    startPulse && !convBusy && !resultAvailable |-> ##[1:800] resultAvailable)
    else $error("result flag late after conversion start");
  chk_ext_start: assert property (
    acqEnable && tmrEff && trigEdge |-> startPulse ##1 convBusy)
    else $error("external edge did not start a conversion");
  chk_overflow_set: assert property (
    ovfEvent |=> state_ff.overflow && state_ff.count == 5'h10)
    else $error("overflow not flagged on full FIFO");
  chk_clear_one: assert property (
    clearWrite && !convOverrun |=> state_ff.count == 5'h01 &&
      !state_ff.overflow && !state_ff.overrun)
    else $error("clear left wrong FIFO fill or flags");
  chk_flag_sticky: assert property (
    (state_ff.overflow || state_ff.overrun) && !clearWrite |=>
      (state_ff.overflow || state_ff.overrun))
    else $error("error flag dropped without clear");
  chk_pair_pop: assert property (
    popReq && !convDone && !clearWrite |=>
      state_ff.count == $past(state_ff.count) - 5'h01)
    else $error("byte pair did not remove one result");
  chk_lsb_keeps: assert property (
    arTake && rdIdx == `AFC_IDX_FIFO_LSB && !convDone && !clearWrite |=>
      $stable(state_ff.count))
    else $error("low byte read changed the FIFO");
  chk_force_high: assert property (
    doWrite && state_ff.wLane && state_ff.awIdx == `AFC_IDX_CNT_MODE &&
      state_ff.wByte == `AFC_MODE_FORCE_HIGH |=> timerLevel [*2])
    else $error("mode write did not force timer high");
  chk_err_status: assert property (
    arTake && rdIdx == `AFC_IDX_STAT1 |=> axiRsp.rdata[`AFC_STAT1_ERR_BIT] ==
      $past(state_ff.overflow || state_ff.overrun))
    else $error("error bit disagrees with flags");
  chk_bresp_hold: assert property (
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped before taken");
endmodule
`default_nettype wire

// ===== hdl/afc_conv_seq.sv
/*
  conversion sequencer: times one conversion, delivers the sign-extended
  result and reports a start that arrives while busy.
  assumes adcCode comes from front-end logic on the same clock.
*/
`include "afc_defines.svh"
`default_nettype none
module afc_conv_seq (
  input wire logic clock,
  input wire logic reset,
  input wire logic startPulse,
  input wire logic [11:0] adcCode,
  output logic doneValid,
  output logic [15:0] doneData,
  output logic overrunPulse,
  output logic busy
);
  afc_pkg::afc_conv_s conv_ff;
  afc_pkg::afc_conv_s nxt_conv;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_conv = conv_ff;
    nxt_conv.doneValid = 1'h0;
    nxt_conv.overrun = 1'h0;
    case (conv_ff.state)
      afc_pkg::CONV_IDLE: begin
        if (startPulse) begin
          nxt_conv.state = afc_pkg::CONV_BUSY;
          nxt_conv.count = 9'(`AFC_CONV_CYCLES - 1);
        end
      end
      afc_pkg::CONV_BUSY: begin
        // start while converting is dropped and flagged
        nxt_conv.overrun = startPulse;
        if (conv_ff.count == 9'h000) begin
          nxt_conv.state = afc_pkg::CONV_IDLE;
          nxt_conv.doneValid = 1'h1;
          // sign extension over four bits
          nxt_conv.doneData = {{4{adcCode[11]}}, adcCode};
        end else begin
          nxt_conv.count = conv_ff.count - 9'h001;
        end
      end
      default: nxt_conv.state = afc_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      conv_ff <= '0;
    end else begin
      conv_ff <= nxt_conv;
    end
  end

  assign doneValid = conv_ff.doneValid;
  assign doneData = conv_ff.doneData;
  assign overrunPulse = conv_ff.overrun;
  assign busy = (conv_ff.state == afc_pkg::CONV_BUSY);

  ////////////////////////////////////////////////////////////////////////////
  chk_conv_done_time: assert property (
    @(posedge clock) disable iff (reset)
    startPulse && !busy |-> ##[401:401] doneValid)
    else $error("conversion did not finish on time");
  chk_result_sext: assert property (
    @(posedge clock) disable iff (reset)
    doneValid |-> (doneData[15:11] == {5{doneData[11]}}))
    else $error("result is not sign extended");
  chk_overrun_pulse: assert property (
    @(posedge clock) disable iff (reset)
    startPulse && busy |=> overrunPulse)
    else $error("start while busy gave no overrun");
endmodule
`default_nettype wire

// ===== hdl/afc_defines.svh
/*
  register indices, field positions, reset values and timing counts of the
  converter and result FIFO control block.
  assumes a 40 MHz clock and a byte address of four times each index.
*/
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

// register indices, byte address is four times the index
`define AFC_IDX_CMD1 5'h00
`define AFC_IDX_STAT1 5'h00
`define AFC_IDX_CLEAR 5'h01
`define AFC_IDX_FIFO_LSB 5'h02
`define AFC_IDX_FIFO_MSB 5'h03
`define AFC_IDX_TIMER_CLR 5'h06
`define AFC_IDX_CMD2 5'h07
`define AFC_IDX_STAT2 5'h07
`define AFC_IDX_CNT0_DATA 5'h08
`define AFC_IDX_CNT_MODE 5'h0B
`define AFC_IDX_CIS_CODE 5'h10
`define AFC_IDX_CIS_LINK 5'h11
`define AFC_IDX_CIS_GAIN 5'h12
`define AFC_IDX_CIS_OFS 5'h13
`define AFC_IDX_CIS_GERR 5'h14

// field positions
`define AFC_STAT1_AVAIL_BIT 0
`define AFC_STAT1_ERR_BIT 1
`define AFC_STAT2_OVF_BIT 0
`define AFC_STAT2_OVR_BIT 1
`define AFC_CMD1_INTEN_BIT 6
`define AFC_CMD2_DISABLE_BIT 1

// reset and command values
`define AFC_CMD1_RESET 8'h80
`define AFC_CMD2_RESET 8'h00
`define AFC_MODE_FORCE_HIGH 8'h34
`define AFC_MODE_FORCE_LOW 8'h30
`define AFC_TUPLE_CODE 8'h81
`define AFC_TUPLE_LINK 8'h03
`define AFC_GAIN_CODE_SE5V 8'h02
`define AFC_RESP_OKAY 2'h0
`define AFC_RESP_SLVERR 2'h2
`define AFC_FIFO_DEPTH 5'h10

// timing
`define AFC_CLK_MHZ 40
`define AFC_CONV_TIME_NS 10000
`define AFC_AVAIL_LIMIT_NS 20000
`define AFC_CONV_CYCLES ((`AFC_CONV_TIME_NS * `AFC_CLK_MHZ) / 1000)
`define AFC_AVAIL_CYCLES ((`AFC_AVAIL_LIMIT_NS * `AFC_CLK_MHZ) / 1000)

`endif

// ===== hdl/afc_pkg.sv
/*
  types of the converter and result FIFO control block.
  assumes afc_defines.svh for all numbers.
*/
`default_nettype none
package afc_pkg;
  typedef enum logic {CONV_IDLE = 1'h0, CONV_BUSY = 1'h1} afc_conv_e;
  typedef enum logic [1:0] {
    TMR_PIN = 2'h0, TMR_HIGH = 2'h1, TMR_LOW = 2'h2
  } afc_tmr_e;

  typedef struct packed {
    logic awvalid; logic [6:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready;
    logic arvalid; logic [6:0] araddr;
    logic rready;
  } afc_axi_req_s;

  typedef struct packed {
    logic awready; logic wready;
    logic bvalid; logic [1:0] bresp;
    logic arready;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } afc_axi_rsp_s;

  typedef struct packed {
    afc_conv_e state; logic [8:0] count;
    logic doneValid; logic [15:0] doneData; logic overrun;
  } afc_conv_s;

  typedef struct packed {
    logic awHave; logic [4:0] awIdx;
    logic wHave; logic [7:0] wByte; logic wLane;
    logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [7:0] rByte; logic [1:0] rresp;
    logic [7:0] cmd1; logic [7:0] cmd2; afc_tmr_e tmrMode;
    logic [2:0] trigSync; logic trigStable; logic prevTrig;
    logic [2:0] tmrSync; logic tmrStable; logic prevTmr;
    logic [15:0][15:0] fifo; logic [3:0] rdPtr; logic [3:0] wrPtr;
    logic [4:0] count; logic lowSeen; logic overflow; logic overrun;
    logic [15:0] lastResult;
  } afc_state_s;
endpackage
`default_nettype wire

// ===== tb/afc_adc_fifo_ctrl_tb_top.sv
/*
  self-checking bench of the converter and result FIFO control block.
  assumes afc_far_model on the pins and an AXI4-Lite register bus.
*/
`include "afc_defines.svh"
`default_nettype none
module afc_adc_fifo_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = `AFC_RESP_OKAY;
  localparam logic [4:0] ST1 = `AFC_IDX_STAT1;
  localparam logic [4:0] ST2 = `AFC_IDX_STAT2;
  localparam logic [4:0] CLR = `AFC_IDX_CLEAR;
  localparam logic [4:0] MODE = `AFC_IDX_CNT_MODE;
  logic clock;
  logic reset;
  afc_pkg::afc_axi_req_s axiReq;
  afc_pkg::afc_axi_rsp_s axiRsp;
  logic sampleTimerOutput;
  logic externalConvertTrigger_n;
  logic [11:0] adcCode;
  logic timerLevel;
  logic resultAvailable;
  logic irqLine;
  int mismatches;
  int n_checks;
  logic [7:0] rd;
  logic [15:0] res;
  logic [11:0] codes [4] = '{12'h800, 12'h7FF, 12'h000, 12'h400};
  ////////////////////////////////////////////////////////////////////////
  afc_adc_fifo_ctrl dut (
    .clock(clock), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp),
    .sampleTimerOutput(sampleTimerOutput),
    .externalConvertTrigger_n(externalConvertTrigger_n),
    .adcCode(adcCode), .timerLevel(timerLevel),
    .resultAvailable(resultAvailable), .irqLine(irqLine)
  );
  afc_far_model far (
    .clock(clock), .sampleTimerOutput(sampleTimerOutput),
    .externalConvertTrigger_n(externalConvertTrigger_n),
    .adcCode(adcCode)
  );
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(input logic [4:0] idx, input logic [7:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= {idx, 2'h0};
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h000000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && n < 100);
    axiReq.bready <= 1'b0;
    chk("bvalid", axiRsp.bvalid, 1'b1);
    chk("bresp", axiRsp.bresp, er);
    @(posedge clock);
  endtask
  task automatic axr(input logic [4:0] idx, input logic [1:0] er,
                     output logic [7:0] d);
    int n;
    n = 0;
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= {idx, 2'h0};
    axiReq.rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && n < 100);
    axiReq.rready <= 1'b0;
    d = axiRsp.rdata[7:0];
    chk("rvalid", axiRsp.rvalid, 1'b1);
    chk("rresp", axiRsp.rresp, er);
    @(posedge clock);
  endtask
  task automatic rchk(input string w, input logic [4:0] idx,
                      input logic [7:0] e);
    logic [7:0] v;
    axr(idx, OK, v);
    chk(w, v, e);
  endtask
  task automatic rdres(output logic [15:0] r);
    logic [7:0] lo;
    logic [7:0] hi;
    axr(`AFC_IDX_FIFO_LSB, OK, lo);
    axr(`AFC_IDX_FIFO_MSB, OK, hi);
    r = {hi, lo};
  endtask
  task automatic waitAvail();
    int n;
    n = 0;
    while (resultAvailable !== 1'b1 && n < 800) begin
      @(posedge clock);
      n++;
    end
    chk("avail", resultAvailable, 1'b1);
  endtask
  function automatic logic [15:0] sx(input logic [11:0] c);
    return {{4{c[11]}}, c};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    axiReq = '0;
    reset = 1'b1;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0; // activation
    @(posedge clock);
    chk("timerLevel", timerLevel, 1'b1);
    axw(`AFC_IDX_CMD1, 8'h80, OK);
    axw(`AFC_IDX_CMD2, 8'h00, OK);
    axw(MODE, 8'h34, OK);
    axw(`AFC_IDX_TIMER_CLR, 8'h00, OK);
    axw(CLR, 8'h00, OK);
    rchk("stat1", ST1, 8'h01);
    rdres(res);
    rchk("stat1", ST1, 8'h00);
    chk("timerLevel", timerLevel, 1'b1);
    rchk("clrRead", CLR, 8'h00);
    rchk("tuple", `AFC_IDX_CIS_CODE, 8'h81);
    axr(5'h1F, `AFC_RESP_SLVERR, rd);
    axw(5'h1F, 8'h00, `AFC_RESP_SLVERR);
    $display("test init done");
    foreach (codes[i]) begin
      far.convert(codes[i]);
      waitAvail();
      chk("irq", irqLine, 1'b0);
      rchk("stat1", ST1, 8'h01);
      rdres(res);
      chk("result", res, sx(codes[i]));
      rchk("stat1", ST1, 8'h00);
    end
    $display("test codes done");
    for (int i = 0; i < 3; i++) begin
      far.convert(codes[i]);
      repeat (420) @(posedge clock);
    end
    for (int i = 0; i < 3; i++) begin
      rdres(res);
      chk("order", res, sx(codes[i]));
    end
    $display("test order done");
    for (int i = 0; i < 17; i++) begin
      far.convert(12'(i));
      repeat (420) @(posedge clock);
    end
    rchk("stat2", ST2, 8'h01);
    rchk("stat1", ST1, 8'h03);
    rdres(res);
    chk("oldest", res, 16'h0000);
    rchk("stat2", ST2, 8'h01);
    axw(CLR, 8'h00, OK);
    rchk("stat2", ST2, 8'h00);
    rchk("stat1", ST1, 8'h01);
    rdres(res);
    chk("stale", res, sx(12'h010));
    rchk("stat1", ST1, 8'h00);
    $display("test overflow done");
    far.convert(12'h123);
    repeat (50) @(posedge clock);
    far.convert(12'h456);
    repeat (420) @(posedge clock);
    rchk("stat2", ST2, 8'h02);
    rchk("stat1", ST1, 8'h03);
    axw(CLR, 8'h00, OK);
    rchk("stat2", ST2, 8'h00);
    rdres(res);
    rchk("stat1", ST1, 8'h00);
    $display("test overrun done");
    axw(MODE, 8'h30, OK);
    chk("timerLow", timerLevel, 1'b0);
    far.convert(12'h321);
    repeat (420) @(posedge clock);
    chk("avail", resultAvailable, 1'b0);
    axw(MODE, 8'h34, OK);
    chk("timerHigh", timerLevel, 1'b1);
    waitAvail();
    axw(`AFC_IDX_CMD1, 8'hC0, OK);
    chk("irqOn", irqLine, 1'b1);
    axw(`AFC_IDX_CMD1, 8'h80, OK);
    chk("irqOff", irqLine, 1'b0);
    rdres(res);
    chk("timerConv", res, sx(12'h321));
    axw(`AFC_IDX_CMD2, 8'h02, OK);
    far.convert(12'h055);
    repeat (420) @(posedge clock);
    chk("avail", resultAvailable, 1'b0);
    axw(`AFC_IDX_CMD2, 8'h00, OK);
    axw(`AFC_IDX_CNT0_DATA, 8'h00, OK);
    chk("timerPin", timerLevel, 1'b1);
    far.pulseTimer();
    waitAvail();
    rdres(res);
    chk("pinConv", res, sx(12'h055));
    axw(MODE, 8'h34, OK);
    chk("timerBack", timerLevel, 1'b1);
    rchk("stat1", ST1, 8'h00);
    $display("test timer done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== tb/afc_far_model.sv
/*
  far side model: external trigger pin, timer pin and front-end code.
  assumes the bench calls convert right after a rising clock edge.
*/
`default_nettype none
module afc_far_model (
  input wire logic clock,
  output logic sampleTimerOutput,
  output logic externalConvertTrigger_n,
  output logic [11:0] adcCode
);
  timeunit 1ns;
  timeprecision 1ps;
  // timer pin held high so the trigger stays effective
  initial begin
    sampleTimerOutput = 1'b1;
    externalConvertTrigger_n = 1'b1;
    adcCode = 12'h000;
  end
  // low pulse, rising edge at the end; code held until next call
  task automatic convert(input logic [11:0] code);
    adcCode <= code;
    externalConvertTrigger_n <= 1'b0;
    repeat (4) @(posedge clock);
    externalConvertTrigger_n <= 1'b1;
    @(posedge clock);
  endtask
  // low pulse on the timer pin, rising edge at the end
  task automatic pulseTimer();
    sampleTimerOutput <= 1'b0;
    repeat (6) @(posedge clock);
    sampleTimerOutput <= 1'b1;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire
